// *** psr_pkg.sv ***
// Package for the peripheral soft reset register block.
// Assumes a 32-bit AXI4-Lite register bus on a single 50 MHz clock.
package psr_pkg;

  // ==========================================================================
  // Register offsets (byte addresses).
  localparam logic [11:0] PSR_GROUP1_OFFSET  = 12'h044;
  localparam logic [11:0] PSR_GPIO_OFFSET    = 12'h048;
  localparam logic [11:0] PSR_CAP_TWO_OFFSET = 12'h080;
  localparam logic [11:0] PSR_CAP_FOUR_OFFSET = 12'h084;

  // ==========================================================================
  // Field positions in the group one register.
  localparam int PSR_COMPARATOR_ZERO_RESET_BIT  = 24;
  localparam int PSR_GP_COUNTER_ZERO_RESET_BIT = 16;
  localparam int PSR_GP_COUNTER_ONE_RESET_BIT = 17;
  localparam int PSR_GP_COUNTER_TWO_RESET_BIT = 18;
  localparam int PSR_SYNC_SERIAL_ZERO_RESET_BIT   = 4;
  localparam int PSR_ASYNC_SERIAL_ONE_RESET_BIT  = 1;
  localparam int PSR_ASYNC_SERIAL_ZERO_RESET_BIT  = 0;
  localparam int PSR_GPIO_WIDTH = 5;

  // Implemented bits of each register.
  localparam logic [31:0] PSR_GROUP1_IMPL = 32'h0107_0013;
  localparam logic [31:0] PSR_GPIO_IMPL   = 32'h0000_001f;

  // ==========================================================================
  // Reset values.
  localparam logic [31:0] PSR_GROUP1_RESET  = 32'h0000_0000;
  localparam logic [31:0] PSR_GPIO_RESET    = 32'h0000_0000;
  localparam logic [31:0] PSR_CAP_TWO_RESET  = 32'h0107_0013;
  localparam logic [31:0] PSR_CAP_FOUR_RESET = 32'h0000_001f;

  // AXI response codes.
  localparam logic [1:0] PSR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PSR_RESP_SLVERR = 2'h2;

endpackage

// *** psr_wr_if.sv ***
// Interface carrying one accepted register write between bus slave and registers.
// Assumes one clock domain; the strobe is a one-cycle pulse.
interface psr_wr_if;
  logic        wr_stb;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;

  modport src (output wr_stb, output wr_addr, output wr_data, output wr_strb);
  modport dst (input wr_stb, input wr_addr, input wr_data, input wr_strb);
endinterface

// *** psr_axi_slave.sv ***
// AXI4-Lite write channel front end for the soft reset block.
// Assumes the master holds each valid until its ready; one write at a time.
module psr_axi_slave
  import psr_pkg::*;
(
  input  wire logic        sys_clk,   // System clock.
  input  wire logic        rst,       // Asynchronous reset, active high.
  input  wire logic [11:0] awaddr,    // Write address.
  input  wire logic        awvalid,   // Write address valid.
  output logic             awready,   // Write address ready.
  input  wire logic [31:0] wdata,     // Write data.
  input  wire logic [3:0]  wstrb,     // Write byte strobes.
  input  wire logic        wvalid,    // Write data valid.
  output logic             wready,    // Write data ready.
  output logic             bvalid,    // Write response valid.
  input  wire logic        bready,    // Write response ready.
  psr_wr_if.src            wr         // Accepted write towards the registers.
);

  logic        aw_have_reg;
  logic        w_have_reg;
  logic [11:0] addr_reg;
  logic [31:0] data_reg;
  logic [3:0]  strb_reg;
  logic        fire;

  // A write completes once address and data are both held and no response is pending.
  assign fire = aw_have_reg && w_have_reg && !bvalid;
  assign awready = !aw_have_reg && !bvalid;
  assign wready  = !w_have_reg && !bvalid;

  // ==========================================================================
  // Address and data capture, in either order.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      addr_reg    <= 12'h000;
      data_reg    <= 32'h0000_0000;
      strb_reg    <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_have_reg <= 1'b1;
        addr_reg    <= awaddr;
      end else if (fire) begin
        aw_have_reg <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_reg <= 1'b1;
        data_reg   <= wdata;
        strb_reg   <= wstrb;
      end else if (fire) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  // Response and the one-cycle write strobe.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bvalid    <= 1'b0;
      wr.wr_stb <= 1'b0;
    end else begin
      wr.wr_stb <= fire;
      if (fire) begin
        bvalid <= 1'b1;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  assign wr.wr_addr = addr_reg;
  assign wr.wr_data = data_reg;
  assign wr.wr_strb = strb_reg;

endmodule

// *** psr_top.sv ***
// Peripheral soft reset registers with AXI4-Lite access.
// Assumes one 50 MHz clock, asynchronous active high reset, well behaved master.
//
// Summary of operation
// - Group one writes masked by capability two.
// - Port writes masked by capability four.
// - Group one bits 24,18:16,4,1,0 read-write.
// - Port register bits 4:0 for ports E..A.
// - Reserved bits read zero; reset clears both control registers.
//
// The AXI4-Lite register port is this design's own decision.
module psr_top
  import psr_pkg::*;
(
  input  wire logic        sys_clk,                  // System clock, 50 MHz.
  input  wire logic        rst,                      // Asynchronous reset, active high.
  input  wire logic [11:0] s_axi_awaddr,             // Write address.
  input  wire logic        s_axi_awvalid,            // Write address valid.
  output logic             s_axi_awready,            // Write address ready.
  input  wire logic [31:0] s_axi_wdata,              // Write data.
  input  wire logic [3:0]  s_axi_wstrb,              // Write byte strobes.
  input  wire logic        s_axi_wvalid,             // Write data valid.
  output logic             s_axi_wready,             // Write data ready.
  output logic [1:0]       s_axi_bresp,              // Write response.
  output logic             s_axi_bvalid,             // Write response valid.
  input  wire logic        s_axi_bready,             // Write response ready.
  input  wire logic [11:0] s_axi_araddr,             // Read address.
  input  wire logic        s_axi_arvalid,            // Read address valid.
  output logic             s_axi_arready,            // Read address ready.
  output logic [31:0]      s_axi_rdata,              // Read data.
  output logic [1:0]       s_axi_rresp,              // Read response.
  output logic             s_axi_rvalid,             // Read data valid.
  input  wire logic        s_axi_rready,             // Read data ready.
  output logic             comparator_zero_reset,    // Comparator 0 held in reset.
  output logic             gp_counter_zero_reset,    // Timer 0 held in reset.
  output logic             gp_counter_one_reset,     // Timer 1 held in reset.
  output logic             gp_counter_two_reset,     // Timer 2 held in reset.
  output logic             sync_serial_zero_reset,   // Serial sync unit held in reset.
  output logic             async_serial_zero_reset,  // UART 0 held in reset.
  output logic             async_serial_one_reset,   // UART 1 held in reset.
  output logic             port_a_reset,             // Port A held in reset.
  output logic             port_b_reset,             // Port B held in reset.
  output logic             port_c_reset,             // Port C held in reset.
  output logic             port_d_reset,             // Port D held in reset.
  output logic             port_e_reset              // Port E held in reset.
);

  // ==========================================================================
  // Register state.
  logic [31:0] peripheral_reset_ctl_group1_reg;
  logic [31:0] gpio_port_reset_ctl_reg;
  logic [31:0] capability_mask_two_reg;
  logic [31:0] capability_mask_four_reg;
  logic        bvalid_int;
  logic        awready_int;
  logic        wready_int;
  logic        rd_pend_reg;    // Read address taken, data due on the next cycle.
  logic [11:0] rd_addr_reg;    // Read address held for the data phase.

  psr_wr_if wr ();

  // ==========================================================================
  // Write channel front end.
  psr_axi_slave u_wr (
    .sys_clk (sys_clk),
    .rst     (rst),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (awready_int),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (wready_int),
    .bvalid  (bvalid_int),
    .bready  (s_axi_bready),
    .wr      (wr)
  );

  assign s_axi_awready = awready_int;
  assign s_axi_wready  = wready_int;
  assign s_axi_bvalid  = bvalid_int;

  // Expands byte strobes to a bit mask.
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // Applies a masked write: only bits allowed by cap and strobes change.
  function automatic logic [31:0] masked_wr(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [31:0] allow);
    return (old_v & ~allow) | (new_v & allow);
  endfunction

  // Tells whether an offset is a mapped register.
  function automatic logic is_mapped(input logic [11:0] a);
    return (a == PSR_GROUP1_OFFSET) || (a == PSR_GPIO_OFFSET) ||
           (a == PSR_CAP_TWO_OFFSET) || (a == PSR_CAP_FOUR_OFFSET);
  endfunction

  // Capability masks are software writable, limited to implemented bits.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      capability_mask_two_reg  <= PSR_CAP_TWO_RESET;
      capability_mask_four_reg <= PSR_CAP_FOUR_RESET;
    end else if (wr.wr_stb) begin
      if (wr.wr_addr == PSR_CAP_TWO_OFFSET) begin
        capability_mask_two_reg <= masked_wr(capability_mask_two_reg, wr.wr_data,
                                             strb_mask(wr.wr_strb) & PSR_GROUP1_IMPL);
      end
      if (wr.wr_addr == PSR_CAP_FOUR_OFFSET) begin
        capability_mask_four_reg <= masked_wr(capability_mask_four_reg, wr.wr_data,
                                              strb_mask(wr.wr_strb) & PSR_GPIO_IMPL);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      peripheral_reset_ctl_group1_reg <= PSR_GROUP1_RESET;
    end else if (wr.wr_stb && wr.wr_addr == PSR_GROUP1_OFFSET) begin
      peripheral_reset_ctl_group1_reg <= masked_wr(peripheral_reset_ctl_group1_reg, wr.wr_data,
        strb_mask(wr.wr_strb) & capability_mask_two_reg & PSR_GROUP1_IMPL);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gpio_port_reset_ctl_reg <= PSR_GPIO_RESET;
    end else if (wr.wr_stb && wr.wr_addr == PSR_GPIO_OFFSET) begin
      gpio_port_reset_ctl_reg <= masked_wr(gpio_port_reset_ctl_reg, wr.wr_data,
        strb_mask(wr.wr_strb) & capability_mask_four_reg & PSR_GPIO_IMPL);
    end
  end

  // Write response code, captured at the edge where the write fires so that it stands with bvalid.
  // Both slots full with no response pending is the fire condition of the front end.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_bresp <= PSR_RESP_OKAY;
    end else if (!bvalid_int && !awready_int && !wready_int) begin
      s_axi_bresp <= is_mapped(wr.wr_addr) ? PSR_RESP_OKAY : PSR_RESP_SLVERR;
    end
  end

  // ==========================================================================
  // Read channel: pulse arready, answer on the cycle after the address handshake, hold until rready.
  // Data only follow a completed address handshake, so rvalid never rises together with arready.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= PSR_RESP_OKAY;
      rd_pend_reg   <= 1'b0;
      rd_addr_reg   <= 12'h000;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arvalid && !s_axi_arready && !rd_pend_reg) begin
        // The address is held from here until the data phase.
        s_axi_arready <= 1'b1;
        rd_pend_reg   <= 1'b1;
        rd_addr_reg   <= s_axi_araddr;
      end else if (rd_pend_reg) begin
        rd_pend_reg   <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= is_mapped(rd_addr_reg) ? PSR_RESP_OKAY : PSR_RESP_SLVERR;
        unique case (rd_addr_reg)
          PSR_GROUP1_OFFSET:   s_axi_rdata <= peripheral_reset_ctl_group1_reg & PSR_GROUP1_IMPL;
          PSR_GPIO_OFFSET:     s_axi_rdata <= gpio_port_reset_ctl_reg & PSR_GPIO_IMPL;
          PSR_CAP_TWO_OFFSET:  s_axi_rdata <= capability_mask_two_reg;
          PSR_CAP_FOUR_OFFSET: s_axi_rdata <= capability_mask_four_reg;
          default:             s_axi_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      comparator_zero_reset   <= 1'b0;
      gp_counter_zero_reset   <= 1'b0;
      gp_counter_one_reset    <= 1'b0;
      gp_counter_two_reset    <= 1'b0;
      sync_serial_zero_reset  <= 1'b0;
      async_serial_zero_reset <= 1'b0;
      async_serial_one_reset  <= 1'b0;
      {port_e_reset, port_d_reset, port_c_reset, port_b_reset, port_a_reset} <= 5'h00;
    end else begin
      comparator_zero_reset   <= peripheral_reset_ctl_group1_reg[PSR_COMPARATOR_ZERO_RESET_BIT];
      gp_counter_zero_reset   <= peripheral_reset_ctl_group1_reg[PSR_GP_COUNTER_ZERO_RESET_BIT];
      gp_counter_one_reset    <= peripheral_reset_ctl_group1_reg[PSR_GP_COUNTER_ONE_RESET_BIT];
      gp_counter_two_reset    <= peripheral_reset_ctl_group1_reg[PSR_GP_COUNTER_TWO_RESET_BIT];
      sync_serial_zero_reset  <= peripheral_reset_ctl_group1_reg[PSR_SYNC_SERIAL_ZERO_RESET_BIT];
      async_serial_zero_reset <= peripheral_reset_ctl_group1_reg[PSR_ASYNC_SERIAL_ZERO_RESET_BIT];
      async_serial_one_reset  <= peripheral_reset_ctl_group1_reg[PSR_ASYNC_SERIAL_ONE_RESET_BIT];
      {port_e_reset, port_d_reset, port_c_reset, port_b_reset, port_a_reset} <=
        gpio_port_reset_ctl_reg[PSR_GPIO_WIDTH-1:0];
    end
  end

  // ==========================================================================
  // Assertions.
  a_group1_cap_mask: assert property (@(posedge sys_clk) disable iff (rst)
    (peripheral_reset_ctl_group1_reg & ~$past(capability_mask_two_reg)) ==
    ($past(peripheral_reset_ctl_group1_reg) & ~$past(capability_mask_two_reg)))
    else $error("Group one bit changed outside capability mask.");

  a_gpio_cap_mask: assert property (@(posedge sys_clk) disable iff (rst)
    (gpio_port_reset_ctl_reg & ~$past(capability_mask_four_reg)) ==
    ($past(gpio_port_reset_ctl_reg) & ~$past(capability_mask_four_reg)))
    else $error("Port register bit changed outside capability mask.");

  a_group1_write_lands: assert property (@(posedge sys_clk) disable iff (rst)
    (wr.wr_stb && wr.wr_addr == PSR_GROUP1_OFFSET && wr.wr_strb == 4'hf) |=>
    peripheral_reset_ctl_group1_reg ==
      ((($past(wr.wr_data) & $past(capability_mask_two_reg)) |
        ($past(peripheral_reset_ctl_group1_reg) & ~$past(capability_mask_two_reg))) & PSR_GROUP1_IMPL))
    else $error("Group one write did not land as masked.");

  a_gpio_write_lands: assert property (@(posedge sys_clk) disable iff (rst)
    (wr.wr_stb && wr.wr_addr == PSR_GPIO_OFFSET && wr.wr_strb[0]) |=>
    gpio_port_reset_ctl_reg[4:0] ==
      ((($past(wr.wr_data[4:0]) & $past(capability_mask_four_reg[4:0])) |
        ($past(gpio_port_reset_ctl_reg[4:0]) & ~$past(capability_mask_four_reg[4:0])))))
    else $error("Port write did not land as masked.");

  a_gpio_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst)
    s_axi_rvalid && $rose(s_axi_rvalid) && rd_addr_reg == PSR_GPIO_OFFSET |->
    s_axi_rdata[31:5] == 27'h0)
    else $error("Reserved port bits read nonzero.");

  a_reset_out_follow: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 (port_a_reset == $past(gpio_port_reset_ctl_reg[0])) &&
        (comparator_zero_reset == $past(peripheral_reset_ctl_group1_reg[PSR_COMPARATOR_ZERO_RESET_BIT])))
    else $error("Peripheral reset output does not follow its bit.");

  // ==========================================================================
  // Steps of a write and a read that the checks below start from.
  // A write strobe towards an address that holds no register.
  sequence s_unmapped_write;
    wr.wr_stb && !is_mapped(wr.wr_addr);
  endsequence

  // The first cycle of a read answer from the group one register.
  sequence s_group1_answer;
    s_axi_rvalid && $rose(s_axi_rvalid) && rd_addr_reg == PSR_GROUP1_OFFSET;
  endsequence

  // The first cycle of a read answer from the port register.
  sequence s_port_answer;
    s_axi_rvalid && $rose(s_axi_rvalid) && rd_addr_reg == PSR_GPIO_OFFSET;
  endsequence

  // The cycle in which the read address is handed over.
  sequence s_addr_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  // A write to no register leaves both control registers alone.
  a_unmapped_keeps: assert property (@(posedge sys_clk) disable iff (rst)
    s_unmapped_write |=> $stable(peripheral_reset_ctl_group1_reg) && $stable(gpio_port_reset_ctl_reg))
    else $error("Unmapped write changed a control register.");

  // A refused write already reports an error code while its strobe is out.
  a_unmapped_slverr: assert property (@(posedge sys_clk) disable iff (rst)
    s_unmapped_write |-> s_axi_bresp == PSR_RESP_SLVERR)
    else $error("Unmapped write answered without an error code.");

  // Group one reads return the stored implemented bits and zero elsewhere.
  a_group1_read_value: assert property (@(posedge sys_clk) disable iff (rst)
    s_group1_answer |-> s_axi_rdata == ($past(peripheral_reset_ctl_group1_reg) & PSR_GROUP1_IMPL))
    else $error("Group one read returned a wrong value.");

  // Read data come one cycle after the address handshake, never with it.
  a_read_after_addr: assert property (@(posedge sys_clk) disable iff (rst)
    s_addr_taken |-> !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("Read data not answered one cycle after the address.");

  // Port reads return the five stored port bits.
  a_port_read_value: assert property (@(posedge sys_clk) disable iff (rst)
    s_port_answer |-> s_axi_rdata == ($past(gpio_port_reset_ctl_reg) & PSR_GPIO_IMPL))
    else $error("Port register read returned a wrong value.");

  // Every group one reset output copies its control bit one cycle later.
  a_group1_outs_follow: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> {comparator_zero_reset, gp_counter_two_reset, gp_counter_one_reset, gp_counter_zero_reset,
              sync_serial_zero_reset, async_serial_one_reset, async_serial_zero_reset} ==
             {$past(peripheral_reset_ctl_group1_reg[PSR_COMPARATOR_ZERO_RESET_BIT]),
              $past(peripheral_reset_ctl_group1_reg[PSR_GP_COUNTER_TWO_RESET_BIT:PSR_GP_COUNTER_ZERO_RESET_BIT]),
              $past(peripheral_reset_ctl_group1_reg[PSR_SYNC_SERIAL_ZERO_RESET_BIT]),
              $past(peripheral_reset_ctl_group1_reg[PSR_ASYNC_SERIAL_ONE_RESET_BIT:PSR_ASYNC_SERIAL_ZERO_RESET_BIT])})
    else $error("Group one reset output does not follow its bit.");

  // Every port reset output copies its control bit one cycle later.
  a_port_outs_follow: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> {port_e_reset, port_d_reset, port_c_reset, port_b_reset, port_a_reset} ==
             $past(gpio_port_reset_ctl_reg[PSR_GPIO_WIDTH-1:0]))
    else $error("Port reset output does not follow its bit.");

endmodule

// *** peripheral_soft_reset_regs_bench.sv ***
// Self-checking bench for the peripheral soft reset register block.
// Assumes psr_top with an AXI4-Lite slave on sys_clk and asynchronous active high rst.
module peripheral_soft_reset_regs_bench
  import psr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Stimulus and observation signals
  logic        sys_clk, rst;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        cmp0, tm0, tm1, tm2, ssi, ua0, ua1, pa, pb, pc, pd, pe;
  logic [31:0] g1_outs, gp_outs;
  int          n_errors = 0;
  int          comparisons = 0;

  // Reset outputs gathered into the bit layout of their control registers.
  assign g1_outs = {7'h00, cmp0, 5'h00, tm2, tm1, tm0, 11'h000, ssi, 2'h0, ua1, ua0};
  assign gp_outs = {27'h0000000, pe, pd, pc, pb, pa};

  psr_top u_psr_top (
    .sys_clk(sys_clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .comparator_zero_reset(cmp0), .gp_counter_zero_reset(tm0), .gp_counter_one_reset(tm1),
    .gp_counter_two_reset(tm2), .sync_serial_zero_reset(ssi), .async_serial_zero_reset(ua0),
    .async_serial_one_reset(ua1), .port_a_reset(pa), .port_b_reset(pb), .port_c_reset(pc),
    .port_d_reset(pd), .port_e_reset(pe)
  );

  // ==========================================================================
  // Clock at 20 ns period.
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ==========================================================================
  // Shared helpers
  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One AXI4-Lite write; address and data offered together, each released when taken.
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    int   t;
    logic aw_done, w_done;
    t = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    r = 2'h3;
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aw_done && w_done) && t < 200) begin
      @(posedge sys_clk);
      t++;
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (t < 200) begin
      @(posedge sys_clk);
      t++;
      if (bvalid === 1'b1) begin
        r = bresp;
        break;
      end
    end
    bready <= 1'b0;
    if (t >= 200) check("write handshake", 32'h0000_0001, 32'h0000_0000);
    // One idle edge keeps the next request apart from this release.
    @(posedge sys_clk);
  endtask

  // One AXI4-Lite read; data and response taken at the edge where rvalid is seen.
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int   t;
    logic ar_done;
    t = 0;
    ar_done = 1'b0;
    d = 32'hdead_beef;
    r = 2'h3;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (t < 200) begin
      @(posedge sys_clk);
      t++;
      if (!ar_done && arready === 1'b1) begin
        ar_done = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
    if (!ar_done) arvalid <= 1'b0;
    rready <= 1'b0;
    if (t >= 200) check("read handshake", 32'h0000_0001, 32'h0000_0000);
    // One idle edge keeps the next request apart from this release.
    @(posedge sys_clk);
  endtask

  // Reads both control registers and compares them, then lets the reset outputs settle and compares them.
  task automatic expect_regs(input logic [31:0] g1, input logic [31:0] gp);
    logic [31:0] v;
    logic [1:0]  r;
    axi_read(PSR_GROUP1_OFFSET, v, r);
    check("group1 readback", g1, v);
    check("group1 rresp", {30'h0, PSR_RESP_OKAY}, {30'h0, r});
    axi_read(PSR_GPIO_OFFSET, v, r);
    check("gpio readback", gp, v);
    repeat (2) @(posedge sys_clk);
    check("group1 reset outputs", g1, g1_outs);
    check("gpio reset outputs", gp, gp_outs);
  endtask

  // ==========================================================================
  // Scenarios
  // Reset values of all four registers and quiet reset outputs.
  task automatic t_reset;
    logic [31:0] v;
    logic [1:0]  r;
    expect_regs(32'h0000_0000, 32'h0000_0000);
    axi_read(PSR_CAP_TWO_OFFSET, v, r);
    check("cap two reset", 32'h0107_0013, v);
    axi_read(PSR_CAP_FOUR_OFFSET, v, r);
    check("cap four reset", 32'h0000_001f, v);
    $display("test reset done");
  endtask

  // All ones written: only implemented bits stick, each holding its peripheral in reset.
  task automatic t_set_all;
    logic [1:0] r;
    axi_write(PSR_GROUP1_OFFSET, 32'hffff_ffff, 4'hf, r);
    check("group1 bresp", {30'h0, PSR_RESP_OKAY}, {30'h0, r});
    axi_write(PSR_GPIO_OFFSET, 32'hffff_ffff, 4'hf, r);
    expect_regs(32'h0107_0013, 32'h0000_001f);
    $display("test set all done");
  endtask

  // Narrowed capability masks protect the bits they leave out.
  task automatic t_masked;
    logic [1:0] r;
    axi_write(PSR_CAP_TWO_OFFSET, 32'h0000_0001, 4'hf, r);
    axi_write(PSR_CAP_FOUR_OFFSET, 32'h0000_0005, 4'hf, r);
    axi_write(PSR_GROUP1_OFFSET, 32'h0000_0000, 4'hf, r);
    axi_write(PSR_GPIO_OFFSET, 32'h0000_0000, 4'hf, r);
    expect_regs(32'h0107_0012, 32'h0000_001a);
    axi_write(PSR_CAP_TWO_OFFSET, 32'hffff_ffff, 4'hf, r);
    axi_write(PSR_CAP_FOUR_OFFSET, 32'hffff_ffff, 4'hf, r);
    $display("test masked done");
  endtask

  // Byte strobes, then a read-modify-write that keeps reserved positions as read.
  task automatic t_strobe_rmw;
    logic [31:0] v;
    logic [1:0]  r;
    axi_write(PSR_GROUP1_OFFSET, 32'h0000_0000, 4'h1, r);
    expect_regs(32'h0107_0000, 32'h0000_001a);
    axi_read(PSR_GROUP1_OFFSET, v, r);
    axi_write(PSR_GROUP1_OFFSET, v & ~32'h0100_0000, 4'hf, r);
    expect_regs(32'h0007_0000, 32'h0000_001a);
    $display("test strobe rmw done");
  endtask

  // Unmapped access is refused, then every peripheral is released.
  task automatic t_unmapped_release;
    logic [31:0] v;
    logic [1:0]  r;
    axi_write(12'h100, 32'hffff_ffff, 4'hf, r);
    check("unmapped bresp", {30'h0, PSR_RESP_SLVERR}, {30'h0, r});
    axi_read(12'h100, v, r);
    check("unmapped rdata", 32'h0000_0000, v);
    check("unmapped rresp", {30'h0, PSR_RESP_SLVERR}, {30'h0, r});
    axi_write(PSR_GROUP1_OFFSET, 32'h0000_0000, 4'hf, r);
    axi_write(PSR_GPIO_OFFSET, 32'h0000_0000, 4'hf, r);
    expect_regs(32'h0000_0000, 32'h0000_0000);
    $display("test unmapped release done");
  endtask

  // ==========================================================================
  // Verdict and run control
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog well beyond the roughly 130 cycles the tests need.
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    print_verdict();
  end

  // Main sequence with reset held for three cycles.
  initial begin
    rst = 1'b1;
    awaddr = 12'h000; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0; wvalid = 1'b0; bready = 1'b0;
    araddr = 12'h000; arvalid = 1'b0; rready = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_set_all();
    t_masked();
    t_strobe_rmw();
    t_unmapped_release();
    print_verdict();
  end
endmodule
